//--- common/sdpo_consts.vh
// Constants for the serial-channel datapath option block.
// Assumes byte addresses on a 32-bit AHB-Lite bus, one word per register.
`ifndef SDPO_CONSTS_VH
`define SDPO_CONSTS_VH

// ==========================================================
// Register byte offsets
`define SDPO_ADDR_CFG 8'h00
`define SDPO_ADDR_RST 8'h04
`define SDPO_ADDR_PLL 8'h08
`define SDPO_ADDR_PPM 8'h0c
`define SDPO_ADDR_STAT 8'h10
`define SDPO_ADDR_RCFG_CTL 8'h14
`define SDPO_ADDR_RCFG_DATA 8'h18
`define SDPO_ADDR_ERR 8'h1c

// ==========================================================
// Reset values
`define SDPO_CFG_RESET 32'h0000_2180
`define SDPO_RST_RESET 32'h0000_0000
`define SDPO_PLL_RESET 32'h0000_0000
`define SDPO_PPM_RESET 32'h0000_0000

// ==========================================================
// Configuration word fields
`define SDPO_CFG_APPW 2:0
`define SDPO_CFG_DEC 4:3
`define SDPO_CFG_INTW 6:5
`define SDPO_CFG_TXBUF 7
`define SDPO_CFG_RXBUF 8
`define SDPO_CFG_RXMAN 9
`define SDPO_CFG_TXREF 10
`define SDPO_CFG_RXREF 11
`define SDPO_CFG_RXUTX 12
`define SDPO_CFG_ENC 13
`define SDPO_CFG_HOLD 14
`define SDPO_CFG_BITS 15

// ==========================================================
// Codes: application width, decoding scheme
`define SDPO_APPW_16 3'h0
`define SDPO_APPW_20 3'h1
`define SDPO_APPW_32 3'h2
`define SDPO_APPW_40 3'h3
`define SDPO_APPW_64 3'h4
`define SDPO_APPW_80 3'h5
`define SDPO_DEC_8B10B 2'h0
`define SDPO_DEC_66 2'h1
`define SDPO_DEC_67 2'h2

// ==========================================================
// Phase interpolator word fields
`define SDPO_PPM_EN 0
`define SDPO_PPM_OVRD 1
`define SDPO_PPM_PD 2
`define SDPO_PPM_DOWN 3
`define SDPO_PPM_STEP 8:4
`define SDPO_PPM_CODE 22:16

`endif

//--- rtl/sdpo_datapath.v
// Parallel datapath options of one serial transceiver channel.
// Assumes the channel symbols and user controls run on clk; status pins do not.
`timescale 1ns/100ps
`include "sdpo_consts.vh"

module sdpo_datapath #(
	parameter NBYTES = 2,
	parameter PLL_VARIANT = 0,
	parameter USE_RECONFIG = 1
) (
	// Clock and reset
	input wire clk,
	input wire rstn,
	// AHB-Lite slave
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire hready,
	input wire [31:0] hwdata,
	output reg hreadyout,
	output reg hresp,
	output reg [31:0] hrdata,
	// Receive datapath
	input wire [NBYTES*10-1:0] rxSymbols,
	output reg [NBYTES*8-1:0] rxData,
	output reg [NBYTES-1:0] rxCommaFlag,
	output reg [NBYTES-1:0] rxControlCharFlag,
	output reg [NBYTES-1:0] rxDecodeError,
	// Transmit datapath
	input wire [NBYTES*8-1:0] txData,
	input wire [NBYTES-1:0] txEncBypassPerByte,
	input wire [NBYTES-1:0] txDisparityMode,
	input wire [NBYTES-1:0] txDisparityValue,
	output reg [NBYTES*8-1:0] txEncData,
	output reg [NBYTES-1:0] txEncodeByte,
	output reg [NBYTES-1:0] txDispMode,
	output reg [NBYTES-1:0] txDispValue,
	// Buffer status pins from the channel
	input wire [1:0] txBufferStatePin,
	input wire [2:0] rxBufferStatePin,
	// Resets and channel controls
	output reg txCodingReset,
	output reg rxCodingReset,
	output reg txAnalogAttachReset,
	output reg rxAnalogAttachReset,
	output reg rxBufferReset,
	output reg txEncoderEnable,
	output reg clockRecoveryHold,
	output reg quadPllPowerdown,
	output reg channelPllPowerdown,
	output reg sharedPllAPowerdown,
	output reg sharedPllBPowerdown,
	output reg [1:0] txRefclkSelect,
	output reg [1:0] rxRefclkSelect,
	// Clock sourcing
	output reg txUserClkFromTxOut,
	output reg rxUserClkFromTxOut,
	output reg txRefclkAsOutclk,
	output reg rxRefclkAsOutclk,
	output reg txBypassManual,
	output reg rxBypassManual,
	// Phase interpolator code
	output reg [6:0] txInterpCode,
	// Reconfiguration port
	output reg rcfgEn,
	output reg rcfgWe,
	output reg [8:0] rcfgAddr,
	output reg [15:0] rcfgDi,
	input wire [15:0] rcfgDo,
	input wire rcfgRdy
);

	// ==========================================================
	// Decode tables, 6b and 4b halves, bit a first
	function [5:0] dec6;
		input [5:0] s;
		begin
			case (s)
				6'h27, 6'h18: dec6 = 6'h20;
				6'h1d, 6'h22: dec6 = 6'h21;
				6'h2d, 6'h12: dec6 = 6'h22;
				6'h31: dec6 = 6'h23;
				6'h35, 6'h0a: dec6 = 6'h24;
				6'h29: dec6 = 6'h25;
				6'h19: dec6 = 6'h26;
				6'h38, 6'h07: dec6 = 6'h27;
				6'h39, 6'h06: dec6 = 6'h28;
				6'h25: dec6 = 6'h29;
				6'h15: dec6 = 6'h2a;
				6'h34: dec6 = 6'h2b;
				6'h0d: dec6 = 6'h2c;
				6'h2c: dec6 = 6'h2d;
				6'h1c: dec6 = 6'h2e;
				6'h17, 6'h28: dec6 = 6'h2f;
				6'h1b, 6'h24: dec6 = 6'h30;
				6'h23: dec6 = 6'h31;
				6'h13: dec6 = 6'h32;
				6'h32: dec6 = 6'h33;
				6'h0b: dec6 = 6'h34;
				6'h2a: dec6 = 6'h35;
				6'h1a: dec6 = 6'h36;
				6'h3a, 6'h05: dec6 = 6'h37;
				6'h33, 6'h0c: dec6 = 6'h38;
				6'h26: dec6 = 6'h39;
				6'h16: dec6 = 6'h3a;
				6'h36, 6'h09: dec6 = 6'h3b;
				6'h0e, 6'h0f, 6'h30: dec6 = 6'h3c;
				6'h2e, 6'h11: dec6 = 6'h3d;
				6'h1e, 6'h21: dec6 = 6'h3e;
				6'h2b, 6'h14: dec6 = 6'h3f;
				default: dec6 = 6'h00;
			endcase
		end
	endfunction

	function [3:0] dec4;
		input [3:0] s;
		begin
			case (s)
				4'hb, 4'h4: dec4 = 4'h8;
				4'h9: dec4 = 4'h9;
				4'h5: dec4 = 4'ha;
				4'hc, 4'h3: dec4 = 4'hb;
				4'hd, 4'h2: dec4 = 4'hc;
				4'ha: dec4 = 4'hd;
				4'h6: dec4 = 4'he;
				4'he, 4'h1, 4'h7, 4'h8: dec4 = 4'hf;
				default: dec4 = 4'h0;
			endcase
		end
	endfunction

	// ==========================================================
	// Register state
	reg [`SDPO_CFG_BITS-1:0] cfg;
	reg [4:0] rst;
	reg [7:0] pll;
	reg [22:0] ppm;
	reg [15:0] errCount;
	reg [15:0] rcfgRead;
	reg rcfgBusy;
	reg [1:0] txStatSync0;
	reg [1:0] txStatSync1;
	reg [2:0] rxStatSync0;
	reg [2:0] rxStatSync1;
	reg wrPend;
	reg rdPend;
	reg [7:0] busAddr;
	reg [31:0] rdMux;
	reg [3:0] bytesUsed;
	reg [57:0] dsState;
	reg [57:0] next_dsState;
	reg [NBYTES*8-1:0] dsOut;
	integer b;
	localparam [31:0] CFG_INIT = `SDPO_CFG_RESET;
	localparam [31:0] RST_INIT = `SDPO_RST_RESET;
	localparam [31:0] PLL_INIT = `SDPO_PLL_RESET;
	localparam [31:0] PPM_INIT = `SDPO_PPM_RESET;

	wire busAcc = hsel & hready & htrans[1];
	wire is8b = cfg[`SDPO_CFG_DEC] == `SDPO_DEC_8B10B;
	wire [NBYTES*8-1:0] decData;
	wire [NBYTES*8-1:0] dsIn;
	wire [NBYTES-1:0] decComma;
	wire [NBYTES-1:0] decK;
	wire [NBYTES-1:0] decBad;
	wire [NBYTES-1:0] laneOn;

	// ==========================================================
	// AHB-Lite: writes take no wait, reads take one
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wrPend <= 1'b0;
			rdPend <= 1'b0;
			busAddr <= 8'h00;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= 32'h0000_0000;
		end else begin
			hresp <= 1'b0;
			if (rdPend) begin
				hrdata <= rdMux;
				hreadyout <= 1'b1;
				rdPend <= 1'b0;
				wrPend <= 1'b0;
			end else if (busAcc) begin
				busAddr <= haddr[7:0];
				wrPend <= hwrite;
				rdPend <= ~hwrite;
				hreadyout <= hwrite;
			end else begin
				wrPend <= 1'b0;
			end
		end
	end

	// Read multiplexer; unmapped words read zero
	always @* begin
		rdMux = 32'h0000_0000;
		if (busAddr == `SDPO_ADDR_CFG) begin
			rdMux[`SDPO_CFG_BITS-1:0] = cfg;
		end else if (busAddr == `SDPO_ADDR_RST) begin
			rdMux[4:0] = rst;
		end else if (busAddr == `SDPO_ADDR_PLL) begin
			rdMux[7:0] = pll;
		end else if (busAddr == `SDPO_ADDR_PPM) begin
			rdMux[22:0] = ppm;
		end else if (busAddr == `SDPO_ADDR_STAT) begin
			rdMux[1:0] = txStatSync1;
			rdMux[4:2] = rxStatSync1;
			rdMux[11:5] = txInterpCode;
			rdMux[12] = txBypassManual;
			rdMux[13] = rxUserClkFromTxOut;
		end else if (busAddr == `SDPO_ADDR_RCFG_CTL) begin
			rdMux[31] = rcfgBusy;
		end else if (busAddr == `SDPO_ADDR_RCFG_DATA) begin
			rdMux[15:0] = rcfgRead;
		end else if (busAddr == `SDPO_ADDR_ERR) begin
			rdMux[15:0] = errCount;
		end
	end

	// ==========================================================
	// Control registers
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cfg <= CFG_INIT[`SDPO_CFG_BITS-1:0];
			rst <= RST_INIT[4:0];
			pll <= PLL_INIT[7:0];
			ppm <= PPM_INIT[22:0];
		end else if (wrPend) begin
			if (busAddr == `SDPO_ADDR_CFG) begin
				// unlisted application width and decoding codes keep the old setting
				cfg[14:7] <= hwdata[14:7];
				if (hwdata[2:0] <= `SDPO_APPW_80)
					cfg[`SDPO_CFG_APPW] <= hwdata[2:0];
				if (hwdata[4:3] != 2'h3)
					cfg[`SDPO_CFG_DEC] <= hwdata[4:3];
				cfg[`SDPO_CFG_INTW] <= hwdata[6:5];
			end else if (busAddr == `SDPO_ADDR_RST) begin
				rst <= hwdata[4:0];
			end else if (busAddr == `SDPO_ADDR_PLL) begin
				pll <= hwdata[7:0];
			end else if (busAddr == `SDPO_ADDR_PPM) begin
				ppm <= hwdata[22:0];
			end
		end
	end

	// ==========================================================
	// Channel controls driven from the registers
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			txCodingReset <= 1'b0;
			rxCodingReset <= 1'b0;
			txAnalogAttachReset <= 1'b0;
			rxAnalogAttachReset <= 1'b0;
			rxBufferReset <= 1'b0;
			txEncoderEnable <= 1'b0;
			clockRecoveryHold <= 1'b0;
			quadPllPowerdown <= 1'b0;
			channelPllPowerdown <= 1'b0;
			sharedPllAPowerdown <= 1'b0;
			sharedPllBPowerdown <= 1'b0;
			txRefclkSelect <= 2'h0;
			rxRefclkSelect <= 2'h0;
			txUserClkFromTxOut <= 1'b0;
			rxUserClkFromTxOut <= 1'b0;
			txRefclkAsOutclk <= 1'b0;
			rxRefclkAsOutclk <= 1'b0;
			txBypassManual <= 1'b0;
			rxBypassManual <= 1'b0;
		end else begin
			// one reset per sublayer and direction
			txCodingReset <= rst[0];
			rxCodingReset <= rst[1];
			txAnalogAttachReset <= rst[2];
			rxAnalogAttachReset <= rst[3];
			// buffer reset silent while the buffer is bypassed
			rxBufferReset <= rst[4] & cfg[`SDPO_CFG_RXBUF];
			txEncoderEnable <= cfg[`SDPO_CFG_ENC];
			clockRecoveryHold <= cfg[`SDPO_CFG_HOLD];
			// only the PLLs of this variant are powered down
			quadPllPowerdown <= (PLL_VARIANT == 0) & pll[0];
			channelPllPowerdown <= (PLL_VARIANT == 0) & pll[1];
			sharedPllAPowerdown <= (PLL_VARIANT != 0) & pll[2];
			sharedPllBPowerdown <= (PLL_VARIANT != 0) & pll[3];
			txRefclkSelect <= pll[5:4];
			rxRefclkSelect <= pll[7:6];
			// transmit user clock from transmit output clock
			txUserClkFromTxOut <= 1'b1;
			// bypassed buffer forces the receive output clock
			rxUserClkFromTxOut <= cfg[`SDPO_CFG_RXUTX] & cfg[`SDPO_CFG_RXBUF];
			// reference clock as output clock when chosen
			txRefclkAsOutclk <= cfg[`SDPO_CFG_TXREF];
			rxRefclkAsOutclk <= cfg[`SDPO_CFG_RXREF];
			// manual alignment whenever the transmit buffer is bypassed
			txBypassManual <= ~cfg[`SDPO_CFG_TXBUF];
			// automatic unless software asks for manual
			rxBypassManual <= ~cfg[`SDPO_CFG_RXBUF] & cfg[`SDPO_CFG_RXMAN];
		end
	end

	// ==========================================================
	// Buffer status pins, synchronised
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			txStatSync0 <= 2'h0;
			txStatSync1 <= 2'h0;
			rxStatSync0 <= 3'h0;
			rxStatSync1 <= 3'h0;
		end else begin
			txStatSync0 <= txBufferStatePin;
			rxStatSync0 <= rxBufferStatePin;
			// status reads zero while its buffer is bypassed
			txStatSync1 <= cfg[`SDPO_CFG_TXBUF] ? txStatSync0 : 2'h0;
			rxStatSync1 <= cfg[`SDPO_CFG_RXBUF] ? rxStatSync0 : 3'h0;
		end
	end

	// ==========================================================
	// Phase interpolator frequency control
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			txInterpCode <= 7'h00;
		end else if (ppm[`SDPO_PPM_PD]) begin
			// powered down controller parks the code
			txInterpCode <= 7'h00;
		end else if (ppm[`SDPO_PPM_OVRD]) begin
			txInterpCode <= ppm[`SDPO_PPM_CODE];
		end else if (ppm[`SDPO_PPM_EN]) begin
			// step up or down by the step size
			if (ppm[`SDPO_PPM_DOWN])
				txInterpCode <= txInterpCode - {2'h0, ppm[`SDPO_PPM_STEP]};
			else
				txInterpCode <= txInterpCode + {2'h0, ppm[`SDPO_PPM_STEP]};
		end
	end

	// ==========================================================
	// Reconfiguration port; a start while busy is ignored
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rcfgEn <= 1'b0;
			rcfgWe <= 1'b0;
			rcfgAddr <= 9'h000;
			rcfgDi <= 16'h0000;
			rcfgRead <= 16'h0000;
			rcfgBusy <= 1'b0;
		end else begin
			rcfgEn <= 1'b0;
			rcfgWe <= 1'b0;
			if (rcfgBusy && rcfgRdy) begin
				rcfgBusy <= 1'b0;
				rcfgRead <= rcfgDo;
			end
			if (wrPend && busAddr == `SDPO_ADDR_RCFG_DATA && !rcfgBusy)
				rcfgDi <= hwdata[15:0];
			// access only when the port is brought out
			if (wrPend && busAddr == `SDPO_ADDR_RCFG_CTL && !rcfgBusy
				&& USE_RECONFIG != 0) begin
				rcfgAddr <= hwdata[8:0];
				rcfgEn <= 1'b1;
				rcfgWe <= hwdata[9];
				rcfgBusy <= 1'b1;
			end
		end
	end

	// ==========================================================
	// bytes carried by the application width
	always @* begin
		case (cfg[`SDPO_CFG_APPW])
			`SDPO_APPW_16, `SDPO_APPW_20: bytesUsed = 4'h2;
			`SDPO_APPW_32, `SDPO_APPW_40: bytesUsed = 4'h4;
			default: bytesUsed = 4'h8;
		endcase
	end

	// Per-lane 8B/10B decode
	genvar g;
	generate
		for (g = 0; g < NBYTES; g = g + 1) begin : lane
			wire [9:0] sym = rxSymbols[g*10+9:g*10];
			wire [5:0] six = {sym[0], sym[1], sym[2], sym[3], sym[4], sym[5]};
			wire [3:0] fghj = {sym[6], sym[7], sym[8], sym[9]};
			wire k28 = (six == 6'h0f) | (six == 6'h30);
			wire [5:0] lo = dec6(six);
			wire [3:0] hi = dec4((six == 6'h30) ? ~fghj : fghj);
			wire alt7 = (fghj == 4'h7) | (fghj == 4'h8);
			wire kx7 = (lo[4:0] == 5'h17) | (lo[4:0] == 5'h1b)
				| (lo[4:0] == 5'h1d) | (lo[4:0] == 5'h1e);
			assign laneOn[g] = g < bytesUsed;
			assign decData[g*8+7:g*8] = {hi[2:0], lo[4:0]};
			assign decK[g] = k28 | (kx7 & alt7);
			// commas are K28.1, K28.5 and K28.7
			assign decComma[g] = k28 & hi[0] & (hi[2:0] != 3'h3);
			assign decBad[g] = ~(lo[5] & hi[3]);
			assign dsIn[g*8+7:g*8] = sym[7:0];
		end
	endgenerate

	// self-synchronous descrambler for the gearbox modes
	always @* begin
		next_dsState = dsState;
		dsOut = {(NBYTES*8){1'b0}};
		for (b = 0; b < NBYTES*8; b = b + 1) begin
			dsOut[b] = dsIn[b] ^ next_dsState[38] ^ next_dsState[57];
			next_dsState = {next_dsState[56:0], dsIn[b]};
		end
	end

	// ==========================================================
	// Receive outputs, registered with their word
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			dsState <= 58'h0;
			rxData <= {(NBYTES*8){1'b0}};
			rxCommaFlag <= {NBYTES{1'b0}};
			rxControlCharFlag <= {NBYTES{1'b0}};
			rxDecodeError <= {NBYTES{1'b0}};
		end else if (rxCodingReset) begin
			dsState <= 58'h0;
			rxData <= {(NBYTES*8){1'b0}};
			rxCommaFlag <= {NBYTES{1'b0}};
			rxControlCharFlag <= {NBYTES{1'b0}};
			rxDecodeError <= {NBYTES{1'b0}};
		end else begin
			if (!is8b)
				dsState <= next_dsState;
			// flags leave with the data they describe
			rxData <= is8b ? decData : dsOut;
			rxCommaFlag <= is8b ? (decComma & laneOn) : {NBYTES{1'b0}};
			rxControlCharFlag <= is8b ? (decK & laneOn) : {NBYTES{1'b0}};
			rxDecodeError <= is8b ? (decBad & laneOn) : {NBYTES{1'b0}};
		end
	end

	// Decode error counter; a clearing write wins, restarting at one if a new error arrives
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			errCount <= 16'h0000;
		end else if (wrPend && busAddr == `SDPO_ADDR_ERR) begin
			errCount <= {15'h0000, |rxDecodeError};
		end else if (|rxDecodeError && errCount != 16'hffff) begin
			errCount <= errCount + 16'h0001;
		end
	end

	// ==========================================================
	// Transmit controls, registered with their word
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			txEncData <= {(NBYTES*8){1'b0}};
			txEncodeByte <= {NBYTES{1'b0}};
			txDispMode <= {NBYTES{1'b0}};
			txDispValue <= {NBYTES{1'b0}};
		end else begin
			txEncData <= txData;
			// encode per byte only when enabled and not bypassed
			txEncodeByte <= ~txEncBypassPerByte & laneOn
				& {NBYTES{cfg[`SDPO_CFG_ENC] & is8b & ~txCodingReset}};
			// disparity controls travel with their byte
			txDispMode <= txDisparityMode & laneOn;
			txDispValue <= txDisparityValue & laneOn;
		end
	end

endmodule // sdpo_datapath

//--- dv/sdpo_datapath_monitor.sv
// Port checker for the serial-channel datapath option block.
// Assumes one clock domain and an active-low asynchronous reset.
`timescale 1ns/100ps

module sdpo_datapath_monitor #(
	parameter NBYTES = 2
) (
	// Clock and reset
	input wire clk,
	input wire rstn,
	// Receive side
	input wire [NBYTES*8-1:0] rxData,
	input wire [NBYTES-1:0] rxCommaFlag,
	input wire [NBYTES-1:0] rxControlCharFlag,
	// Transmit side
	input wire [NBYTES*8-1:0] txData,
	input wire [NBYTES-1:0] txEncBypassPerByte,
	input wire [NBYTES-1:0] txDisparityMode,
	input wire [NBYTES-1:0] txDisparityValue,
	input wire [NBYTES*8-1:0] txEncData,
	input wire [NBYTES-1:0] txEncodeByte,
	input wire [NBYTES-1:0] txDispMode,
	input wire [NBYTES-1:0] txDispValue,
	// Controls
	input wire txCodingReset,
	input wire rxCodingReset,
	input wire txUserClkFromTxOut,
	input wire rcfgEn
);
	default clocking dcb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	property p_tx_user_clk;
		$past(rstn) |-> txUserClkFromTxOut;
	endproperty
	a_tx_user_clk: assert property (p_tx_user_clk)
		else $error("tx user clock not sourced from tx output clock");
	property p_bypass_skip;
		$past(rstn) |-> (txEncodeByte & $past(txEncBypassPerByte)) == {NBYTES{1'b0}};
	endproperty
	a_bypass_skip: assert property (p_bypass_skip)
		else $error("bypassed byte still encoded");
	property p_disp_follow;
		$past(rstn) && !$past(txCodingReset) && !txCodingReset |->
			txDispMode == $past(txDisparityMode) && txDispValue == $past(txDisparityValue);
	endproperty
	a_disp_follow: assert property (p_disp_follow)
		else $error("disparity controls not aligned with their byte");
	property p_enc_data;
		$past(rstn) && !$past(txCodingReset) && !txCodingReset |-> txEncData == $past(txData);
	endproperty
	a_enc_data: assert property (p_enc_data)
		else $error("tx data not aligned with its controls");
	property p_comma_is_k;
		(rxCommaFlag & ~rxControlCharFlag) == {NBYTES{1'b0}};
	endproperty
	a_comma_is_k: assert property (p_comma_is_k)
		else $error("comma flagged without control flag");
	property p_comma_code;
		rxCommaFlag[0] |-> rxData[7:0] inside {8'h3c, 8'hbc, 8'hfc};
	endproperty
	a_comma_code: assert property (p_comma_code)
		else $error("comma flag on a non-comma byte");
	property p_k_code;
		rxControlCharFlag[1] |-> rxData[12:8] == 5'h1c || rxData[15:8] inside {8'hf7, 8'hfb, 8'hfd, 8'hfe};
	endproperty
	a_k_code: assert property (p_k_code)
		else $error("control flag on a data byte");
	property p_rx_reset_clear;
		rxCodingReset && $past(rxCodingReset) |-> rxData == '0 && rxControlCharFlag == '0;
	endproperty
	a_rx_reset_clear: assert property (p_rx_reset_clear)
		else $error("receive outputs live during coding reset");
	property p_tx_reset_noenc;
		txCodingReset ##1 txCodingReset |-> txEncodeByte == {NBYTES{1'b0}};
	endproperty
	a_tx_reset_noenc: assert property (p_tx_reset_noenc)
		else $error("encoding during tx coding reset");
	property p_rcfg_pulse;
		rcfgEn |=> !rcfgEn [*2];
	endproperty
	a_rcfg_pulse: assert property (p_rcfg_pulse)
		else $error("reconfiguration enable not a single pulse");
endmodule // sdpo_datapath_monitor

//--- dv/sdpo_fabric_model.sv
// Far-side model of the reconfiguration port.
// Assumes one access at a time; answers after one cycle, or nine when slow.
`timescale 1ns/100ps

module sdpo_fabric_model (
	// Clock and reset
	input wire clk,
	input wire rstn,
	// Answer speed
	input wire slow,
	// Reconfiguration port
	input wire rcfgEn,
	input wire rcfgWe,
	input wire [8:0] rcfgAddr,
	input wire [15:0] rcfgDi,
	output reg [15:0] rcfgDo,
	output reg rcfgRdy
);
	reg [15:0] mem [0:511];
	reg [8:0] addr;
	reg [3:0] waitCnt;

	// access answered by ready pulse, read data valid only with it
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			waitCnt <= 4'h0;
			rcfgRdy <= 1'b0;
			rcfgDo <= 16'h0;
			addr <= 9'h0;
		end else begin
			rcfgRdy <= 1'b0;
			rcfgDo <= ~rcfgDo;
			if (rcfgEn) begin
				addr <= rcfgAddr;
				waitCnt <= slow ? 4'h9 : 4'h1;
				if (rcfgWe) begin
					mem[rcfgAddr] <= rcfgDi;
				end
			end else if (waitCnt != 4'h0) begin
				waitCnt <= waitCnt - 4'h1;
				if (waitCnt == 4'h1) begin
					rcfgRdy <= 1'b1;
					rcfgDo <= mem[addr];
				end
			end
		end
	end
endmodule // sdpo_fabric_model

//--- dv/test_serdes_pcs_datapath_options.sv
// Self-checking bench for the serial-channel datapath option block.
// Assumes the block's constants header is on the include path.
`timescale 1ns/100ps
`include "sdpo_consts.vh"

module test_serdes_pcs_datapath_options;
	localparam NBYTES = 2;
	reg clk, rstn, hsel, hwrite, slow;
	reg [31:0] haddr, hwdata, rd;
	reg [1:0] htrans, txEncBypassPerByte, txDisparityMode, txDisparityValue, txBufferStatePin;
	reg [2:0] hsize, rxBufferStatePin;
	reg [19:0] rxSymbols;
	reg [15:0] txData;
	reg [6:0] code0;
	wire hreadyout, hresp, txEncoderEnable, clockRecoveryHold, rcfgEn, rcfgWe, rcfgRdy;
	wire [31:0] hrdata;
	wire [15:0] rxData, txEncData, rcfgDi, rcfgDo;
	wire [1:0] rxCommaFlag, rxControlCharFlag, rxDecodeError, txEncodeByte, txDispMode;
	wire [1:0] txDispValue, txRefclkSelect, rxRefclkSelect;
	wire txCodingReset, rxCodingReset, txAnalogAttachReset, rxAnalogAttachReset, rxBufferReset;
	wire quadPllPowerdown, channelPllPowerdown, sharedPllAPowerdown, sharedPllBPowerdown;
	wire txUserClkFromTxOut, rxUserClkFromTxOut, txRefclkAsOutclk, rxRefclkAsOutclk;
	wire txBypassManual, rxBypassManual;
	wire [6:0] txInterpCode;
	wire [8:0] rcfgAddr;
	integer errorCnt, nTests, i;

	sdpo_datapath #(.NBYTES(NBYTES)) u_sdpo_datapath (.clk, .rstn, .hsel, .haddr, .htrans,
		.hwrite, .hsize, .hready(hreadyout), .hwdata, .hreadyout, .hresp, .hrdata, .rxSymbols,
		.rxData, .rxCommaFlag, .rxControlCharFlag, .rxDecodeError, .txData, .txEncBypassPerByte,
		.txDisparityMode, .txDisparityValue, .txEncData, .txEncodeByte, .txDispMode, .txDispValue,
		.txBufferStatePin, .rxBufferStatePin, .txCodingReset, .rxCodingReset, .txAnalogAttachReset,
		.rxAnalogAttachReset, .rxBufferReset, .txEncoderEnable, .clockRecoveryHold,
		.quadPllPowerdown, .channelPllPowerdown, .sharedPllAPowerdown, .sharedPllBPowerdown,
		.txRefclkSelect, .rxRefclkSelect, .txUserClkFromTxOut, .rxUserClkFromTxOut,
		.txRefclkAsOutclk, .rxRefclkAsOutclk, .txBypassManual, .rxBypassManual, .txInterpCode,
		.rcfgEn, .rcfgWe, .rcfgAddr, .rcfgDi, .rcfgDo, .rcfgRdy);
	sdpo_fabric_model u_sdpo_fabric_model (.clk, .rstn, .slow, .rcfgEn, .rcfgWe, .rcfgAddr,
		.rcfgDi, .rcfgDo, .rcfgRdy);

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// ============================================================
	// Tasks
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		nTests = nTests + 1;
		if (got !== exp) begin
			errorCnt = errorCnt + 1;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= wr;
		htrans <= 2'h2;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		rd = hrdata;
	endtask
	task wrSettle(input logic [7:0] a, input logic [31:0] wd);
		ahb(1'b1, a, wd);
		@(posedge clk);
		@(negedge clk);
	endtask
	task rdChk(input string what, input logic [7:0] a, input logic [31:0] msk,
		input logic [31:0] exp);
		ahb(1'b0, a, 32'h0);
		chk("hresp", 32'h0, {31'h0, hresp});
		chk(what, exp, rd & msk);
	endtask
	task rxChk(input logic [9:0] s1, input logic [9:0] s0, input logic [15:0] d,
		input logic [1:0] cm, input logic [1:0] k, input logic useData);
		@(posedge clk);
		rxSymbols <= {s1, s0};
		@(posedge clk);
		@(negedge clk);
		if (useData) chk("rx data", {16'h0, d}, {16'h0, rxData});
		chk("rx flags", {26'h0, cm, k, 2'h0},
			{26'h0, rxCommaFlag, rxControlCharFlag, rxDecodeError});
	endtask
	task txChk(input logic [1:0] b, input logic [1:0] expEnc);
		@(posedge clk);
		txData <= {6'h2a, b, 8'h5c};
		txEncBypassPerByte <= b;
		txDisparityMode <= b;
		txDisparityValue <= ~b;
		@(posedge clk);
		@(negedge clk);
		chk("tx enc byte", {30'h0, expEnc}, {30'h0, txEncodeByte});
		chk("tx lane", {6'h2a, b, 8'h5c, 4'h0, b, ~b}, {txEncData, 4'h0, txDispMode, txDispValue});
	endtask
	task complete_run;
		$display("Checks %0d, mismatches %0d", nTests, errorCnt);
		if (errorCnt == 0 && nTests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// ============================================================
	// Tests
	initial begin
		errorCnt = 0;
		nTests = 0;
		{rstn, hsel, hwrite, slow, htrans, haddr, hwdata} = '0;
		{rxSymbols, txData, txEncBypassPerByte, txDisparityMode, txDisparityValue} = '0;
		hsize = 3'h2;
		txBufferStatePin = 2'h2;
		rxBufferStatePin = 3'h5;
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		rdChk("cfg", `SDPO_ADDR_CFG, 32'hffffffff, `SDPO_CFG_RESET);
		rdChk("pll", `SDPO_ADDR_PLL, 32'hffffffff, `SDPO_PLL_RESET);
		ahb(1'b1, 8'h20, 32'hffffffff);
		rdChk("unmapped", 8'h20, 32'hffffffff, 32'h0);
		@(negedge clk);
		chk("clk src", 32'h3, {30'h0, txUserClkFromTxOut, txEncoderEnable});
		// Buffers in use: rx user clock may follow tx output clock
		wrSettle(`SDPO_ADDR_CFG, 32'h0000_3180);
		rdChk("stat", `SDPO_ADDR_STAT, 32'h201f, 32'h2016);
		rxSymbols <= {10'h283, 10'h17c};
		wrSettle(`SDPO_ADDR_RST, 32'h1f);
		chk("resets", 32'h1f, {27'h0, rxBufferReset, rxAnalogAttachReset, txAnalogAttachReset,
			rxCodingReset, txCodingReset});
		// Buffers bypassed
		wrSettle(`SDPO_ADDR_CFG, 32'h0000_7c00);
		wrSettle(`SDPO_ADDR_RST, 32'h10);
		chk("bufreset", 32'h0, {31'h0, rxBufferReset});
		chk("bypass", 32'h27, {26'h0, txBypassManual, rxBypassManual, rxUserClkFromTxOut,
			txRefclkAsOutclk, rxRefclkAsOutclk, clockRecoveryHold});
		rdChk("stat off", `SDPO_ADDR_STAT, 32'h201f, 32'h0);
		wrSettle(`SDPO_ADDR_CFG, `SDPO_CFG_RESET);
		wrSettle(`SDPO_ADDR_RST, 32'h0);
		wrSettle(`SDPO_ADDR_PLL, 32'hab);
		chk("pll pd", 32'hc, {28'h0, quadPllPowerdown, channelPllPowerdown, sharedPllAPowerdown,
			sharedPllBPowerdown});
		chk("refsel", 32'ha, {28'h0, txRefclkSelect, rxRefclkSelect});
		// Receive decode, both disparities and several K codes
		rxChk(10'h283, 10'h17c, 16'hbcbc, 2'h3, 2'h3, 1'b1);
		rxChk(10'h17c, 10'h155, 16'hbcb5, 2'h2, 2'h2, 1'b1);
		rxChk(10'h155, 10'h0bc, 16'hb51c, 2'h0, 2'h1, 1'b1);
		rxChk(10'h27c, 10'h07c, 16'h3cfc, 2'h3, 2'h3, 1'b1);
		for (i = 1; i < 3; i = i + 1) begin
			wrSettle(`SDPO_ADDR_CFG, 32'h2180 | (i << 3));
			rxChk(10'h283, 10'h17c, 16'h0, 2'h0, 2'h0, 1'b0);
		end
		// Transmit per-byte controls
		wrSettle(`SDPO_ADDR_CFG, `SDPO_CFG_RESET);
		for (i = 0; i < 4; i = i + 1) txChk(i[1:0], ~i[1:0]);
		wrSettle(`SDPO_ADDR_CFG, 32'h0180);
		txChk(2'h0, 2'h0);
		wrSettle(`SDPO_ADDR_CFG, 32'h21ef);
		txChk(2'h0, 2'h0);
		rdChk("cfg keep", `SDPO_ADDR_CFG, 32'hffff, 32'h21e8);
		// Phase interpolator: override, step up, step down, power-down
		wrSettle(`SDPO_ADDR_PPM, 32'h0055_0002);
		chk("ppm ovrd", 32'h55, {25'h0, txInterpCode});
		for (i = 0; i < 3; i = i + 1) begin
			wrSettle(`SDPO_ADDR_PPM, 32'h31 | (i[0] << 3) | (i[1] << 2));
			code0 = txInterpCode;
			@(negedge clk);
			chk("ppm step", {25'h0, code0 + (i == 0 ? 7'h3 : i == 1 ? 7'h7d : 7'h0)},
				{25'h0, txInterpCode});
		end
		rdChk("stat code", `SDPO_ADDR_STAT, 32'hfe0, {20'h0, code0, 5'h0});
		// Reconfiguration port, prompt then slow
		for (i = 0; i < 2; i = i + 1) begin
			slow <= i[0];
			ahb(1'b1, `SDPO_ADDR_RCFG_DATA, 32'h1234 + i);
			ahb(1'b1, `SDPO_ADDR_RCFG_CTL, 32'h240 + i);
			rd = 32'h8000_0000;
			while (rd[31]) ahb(1'b0, `SDPO_ADDR_RCFG_CTL, 32'h0);
			ahb(1'b1, `SDPO_ADDR_RCFG_CTL, 32'h40 + i);
			rd = 32'h8000_0000;
			while (rd[31]) ahb(1'b0, `SDPO_ADDR_RCFG_CTL, 32'h0);
			rdChk("rcfg", `SDPO_ADDR_RCFG_DATA, 32'hffff, 32'h1234 + i);
		end
		complete_run;
	end

	initial begin
		repeat (20000) @(posedge clk);
		errorCnt = errorCnt + 1;
		complete_run;
	end
endmodule // test_serdes_pcs_datapath_options

bind sdpo_datapath sdpo_datapath_monitor #(.NBYTES(NBYTES)) u_sdpo_datapath_monitor (.clk,
	.rstn, .rxData, .rxCommaFlag, .rxControlCharFlag, .txData, .txEncBypassPerByte,
	.txDisparityMode, .txDisparityValue, .txEncData, .txEncodeByte, .txDispMode, .txDispValue,
	.txCodingReset, .rxCodingReset, .txUserClkFromTxOut, .rcfgEn);
